/* File: rtl/cpw_pkg.sv */
// constants shared by the cascaded pwm block and its source clock selector
// assumes a single 25 MHz clock and an apb slave register file
package cpw_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] CPW_OFS_CTRL = 8'h00;
  localparam logic [7:0] CPW_OFS_MODE = 8'h04;
  localparam logic [7:0] CPW_OFS_DUTYLO = 8'h08;
  localparam logic [7:0] CPW_OFS_DUTYHI = 8'h0c;
  localparam logic [7:0] CPW_OFS_STATUS = 8'h10;
  localparam logic [7:0] CPW_OFS_EFFDUTY = 8'h14;

  // ==========================================================
  // field positions
  localparam int CPW_CTRL_RUN = 0;
  localparam int CPW_MODE_IDLE = 0;
  localparam int CPW_MODE_BUFEN = 1;
  localparam int CPW_MODE_EXTCLK = 2;
  localparam int CPW_MODE_SEL_LO = 4;
  localparam int CPW_MODE_LOWSPD = 8;
  localparam int CPW_MODE_SLOWPRE = 9;

  // ==========================================================
  // reset values
  localparam logic [7:0] CPW_DUTY_RST = 8'hff;
  localparam logic [11:0] CPW_EFF_RST = 12'hfff;
  localparam logic [9:0] CPW_MODE_RST = 10'h000;

  // ==========================================================
  // counter and superframe figures
  localparam logic [7:0] CPW_CNT_TOP = 8'hff;
  localparam logic [7:0] CPW_CNT_ZERO = 8'h00;
  localparam logic [3:0] CPW_LAST_PERIOD = 4'hf;
  localparam logic [4:0] CPW_B0_PERIOD = 5'h09;
  localparam logic [2:0] CPW_B1_PHASE = 3'h5;
  localparam logic [1:0] CPW_B2_PHASE = 2'h3;

  // ==========================================================
  // gear clock divider masks, one per clock select code
  localparam int CPW_GEAR_W = 11;
  localparam logic [10:0] CPW_GEAR_MASK [8] = '{
    11'h7ff, 11'h3ff, 11'h0ff, 11'h03f, 11'h00f, 11'h003, 11'h001, 11'h000
  };
  // low frequency divider masks (/16, /8, /4)
  localparam logic [3:0] CPW_LF_DIV16 = 4'hf;
  localparam logic [3:0] CPW_LF_DIV8 = 4'h7;
  localparam logic [3:0] CPW_LF_DIV4 = 4'h3;
  localparam logic [2:0] CPW_SEL_LF16 = 3'h0;
  localparam logic [2:0] CPW_SEL_LF8 = 3'h1;
  localparam logic [2:0] CPW_SEL_LF4 = 3'h7;

endpackage

/* File: rtl/cpw_src_clock.sv */
// source clock selector: gear divider, low frequency divider, external pin
// assumes all pins synchronous to clk; emits one-cycle enable pulses
`timescale 1ns/1ps
`default_nettype none
module cpw_src_clock #(
  parameter int GEAR_W = cpw_pkg::CPW_GEAR_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] clockSelectField,
  input wire logic extClkSel,
  input wire logic lowSpeedMode,
  input wire logic slowPrescaleSelect,
  input wire logic extClockPin,
  input wire logic lowFreqClock,
  output logic srcTick
);
  import cpw_pkg::*;

  // ==========================================================
  // elaboration check
  if (GEAR_W != CPW_GEAR_W)
  begin : g_bad_width
    $error("gear divider width must match the mask table");
  end

  logic [GEAR_W-1:0] gearCnt_r, gearCnt_nxt;
  logic [3:0] lfCnt_r, lfCnt_nxt;
  logic lfPrev_r, extPrev_r;
  logic tick_r, tick_nxt;
  logic lfEdge, extEdge;

  // ==========================================================
  // dividers and edge pick
  always_comb
  begin
    lfEdge = lowFreqClock & ~lfPrev_r;
    extEdge = extClockPin & ~extPrev_r; // rising edge, pin held two cycles [R4]
    gearCnt_nxt = gearCnt_r + 1'b1;
    lfCnt_nxt = lfEdge ? lfCnt_r + 1'b1 : lfCnt_r;
    tick_nxt = 1'b0;
    if (extClkSel)
    begin
      tick_nxt = extEdge; // outside party keeps pin under half the gear rate [R3]
    end
    else if (lowSpeedMode || (slowPrescaleSelect && clockSelectField <= CPW_SEL_LF8))
    begin
      // only fs/16, fs/8, fs/4 are valid here [R20]
      unique case (clockSelectField)
        CPW_SEL_LF16: tick_nxt = lfEdge && ((lfCnt_r & CPW_LF_DIV16) == CPW_LF_DIV16);
        CPW_SEL_LF8: tick_nxt = lfEdge && ((lfCnt_r & CPW_LF_DIV8) == CPW_LF_DIV8);
        CPW_SEL_LF4: tick_nxt = lfEdge && ((lfCnt_r & CPW_LF_DIV4) == CPW_LF_DIV4);
        default: tick_nxt = 1'b0;
      endcase
    end
    else
    begin
      // gear clock divided by 2^11 .. 1 [R14]
      tick_nxt = (gearCnt_r & CPW_GEAR_MASK[clockSelectField]) == CPW_GEAR_MASK[clockSelectField];
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      gearCnt_r <= '0;
      lfCnt_r <= 4'h0;
      lfPrev_r <= 1'b0;
      extPrev_r <= 1'b0;
      tick_r <= 1'b0;
    end
    else
    begin
      gearCnt_r <= gearCnt_nxt;
      lfCnt_r <= lfCnt_nxt;
      lfPrev_r <= lowFreqClock;
      extPrev_r <= extClockPin;
      tick_r <= tick_nxt;
    end
  end

  assign srcTick = tick_r;

endmodule
`default_nettype wire

/* File: rtl/cpw_cascaded_pwm.sv */
// cascaded 12-bit pwm: 8-bit duty compare, 4-bit period stretching, apb registers
// assumes apb master on clk, synchronous active-low reset, pins synchronous
// Overview of operation
// R1 - clearing run halts counter, clears to zero
// R2 - stopped output returns to idle level
// R3 - external clock within allowed frequency limit
// R4 - external clock phases last two cycles
// R5 - buffer enable bit selects double buffering
// R6 - running buffered write lands only in buffer
// R7 - sixteenth overflow raises irq, commits buffer
// R8 - buffered duty reads return last written
// R9 - stopped buffered write updates both copies
// R10 - unbuffered write takes effect at once
// R11 - duty below count waits for overflow
// R12 - duty equal to count matches immediately
// R13 - unbuffered write during stretch shifts edge
// R14 - clock select code picks gear divisor
// R15 - output inverts at duty or duty+1
// R16 - mask bits stretch fixed superframe periods
// R17 - wrap at 256, idle level, overflow irq
// R18 - software writes low then high duty
// R19 - stopping resets superframe position
// R20 - low speed allows only fs divisors
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cpw_cascaded_pwm (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extClockPin,
  input wire logic lowFreqClock,
  output logic modulatedOutPin,
  output logic overflowIrq,
  output logic superframeIrq
);
  import cpw_pkg::*;

  // ==========================================================
  // register state
  logic run_r, run_nxt;
  logic [9:0] mode_r, mode_nxt;
  logic [7:0] dutyLow_r, dutyLow_nxt;
  logic [7:0] dutyHigh_r, dutyHigh_nxt;
  logic [11:0] dutyBuf_r, dutyBuf_nxt;
  logic [11:0] effDuty_r, effDuty_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;

  // ==========================================================
  // counter state
  logic [7:0] count_r, count_nxt;
  logic [3:0] period_r, period_nxt;
  logic matched_r, matched_nxt;
  logic pin_r, pin_nxt;
  logic ovf_r, ovf_nxt;
  logic sf_r, sf_nxt;

  logic srcTick;
  logic idleLevel, bufferEnableBit;
  logic access, wrStrobe, mapped;
  logic hiWrite;
  logic [11:0] newDuty;
  logic [4:0] periodNum;
  logic stretch;
  logic [8:0] target;
  logic wrap, commit;

  assign idleLevel = mode_r[CPW_MODE_IDLE];
  assign bufferEnableBit = mode_r[CPW_MODE_BUFEN];

  // ==========================================================
  // source clock selector
  cpw_src_clock #(
    .GEAR_W(CPW_GEAR_W)
  ) u_src (
    .clk(clk),
    .nrst(nrst),
    .clockSelectField(mode_r[CPW_MODE_SEL_LO +: 3]),
    .extClkSel(mode_r[CPW_MODE_EXTCLK]),
    .lowSpeedMode(mode_r[CPW_MODE_LOWSPD]),
    .slowPrescaleSelect(mode_r[CPW_MODE_SLOWPRE]),
    .extClockPin(extClockPin),
    .lowFreqClock(lowFreqClock),
    .srcTick(srcTick)
  );

  // ==========================================================
  // apb decode, one wait state
  always_comb
  begin
    access = psel & penable;
    wrStrobe = access & pready_r & pwrite;
    mapped = (paddr == CPW_OFS_CTRL) || (paddr == CPW_OFS_MODE) || (paddr == CPW_OFS_DUTYLO)
      || (paddr == CPW_OFS_DUTYHI) || (paddr == CPW_OFS_STATUS) || (paddr == CPW_OFS_EFFDUTY);
    pready_nxt = access & ~pready_r;
    pslverr_nxt = access & ~pready_r & ~mapped;
    prdata_nxt = 32'h0000_0000;
    if (access && !pready_r && !pwrite)
    begin
      unique case (paddr)
        CPW_OFS_CTRL: prdata_nxt = {31'h0, run_r};
        CPW_OFS_MODE: prdata_nxt = {22'h0, mode_r};
        CPW_OFS_DUTYLO: prdata_nxt = {24'h00_0000, dutyLow_r}; // last written copy [R8]
        CPW_OFS_DUTYHI: prdata_nxt = {24'h00_0000, dutyHigh_r}; // [R8]
        CPW_OFS_STATUS: prdata_nxt = {18'h0, run_r, pin_r, period_r, count_r};
        CPW_OFS_EFFDUTY: prdata_nxt = {20'h0_0000, effDuty_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // software registers and duty buffering
  always_comb
  begin
    run_nxt = run_r;
    mode_nxt = mode_r;
    dutyLow_nxt = dutyLow_r;
    dutyHigh_nxt = dutyHigh_r;
    dutyBuf_nxt = dutyBuf_r;
    effDuty_nxt = effDuty_r;
    hiWrite = wrStrobe && (paddr == CPW_OFS_DUTYHI);
    newDuty = {pwdata[3:0], dutyLow_r}; // low written first by software [R18]
    if (wrStrobe && paddr == CPW_OFS_CTRL)
    begin
      run_nxt = pwdata[CPW_CTRL_RUN];
    end
    if (wrStrobe && paddr == CPW_OFS_MODE && !run_r)
    begin
      mode_nxt = pwdata[9:0]; // mode frozen while running
    end
    if (wrStrobe && paddr == CPW_OFS_DUTYLO)
    begin
      dutyLow_nxt = pwdata[7:0];
    end
    if (commit)
    begin
      effDuty_nxt = dutyBuf_r; // superframe commit [R7]
    end
    if (hiWrite)
    begin
      dutyHigh_nxt = pwdata[7:0];
      dutyBuf_nxt = newDuty;
      if (!bufferEnableBit || !run_r) // buffer select [R5]
      begin
        effDuty_nxt = newDuty; // immediate effect [R9] [R10]
      end
      // running and buffered: effective copy untouched [R6]
    end
  end

  // ==========================================================
  // stretch selection for the current period
  always_comb
  begin
    periodNum = {1'b0, period_r} + 5'h01;
    stretch = (effDuty_r[0] && periodNum == CPW_B0_PERIOD)
      || (effDuty_r[1] && periodNum[2:0] == CPW_B1_PHASE)
      || (effDuty_r[2] && periodNum[1:0] == CPW_B2_PHASE)
      || (effDuty_r[3] && !periodNum[0]); // fixed period pattern [R16]
    target = {1'b0, effDuty_r[11:4]} + {8'h00, stretch}; // duty or duty+1 [R15]
  end

  // ==========================================================
  // up counter, output pin and event pulses
  always_comb
  begin
    wrap = run_r && srcTick && (count_r == CPW_CNT_TOP);
    commit = wrap && bufferEnableBit && (period_r == CPW_LAST_PERIOD);
    count_nxt = count_r;
    period_nxt = period_r;
    matched_nxt = matched_r;
    pin_nxt = pin_r;
    ovf_nxt = 1'b0;
    sf_nxt = 1'b0;
    if (!run_r)
    begin
      count_nxt = CPW_CNT_ZERO; // halt and clear [R1]
      period_nxt = 4'h0; // superframe restarts [R19]
      matched_nxt = 1'b0;
      pin_nxt = idleLevel; // idle level while stopped [R2]
    end
    else if (wrap)
    begin
      count_nxt = CPW_CNT_ZERO; // wrap at 256 [R17]
      period_nxt = period_r + 4'h1;
      matched_nxt = 1'b0;
      pin_nxt = idleLevel; // [R17]
      ovf_nxt = 1'b1; // [R17]
      sf_nxt = (period_r == CPW_LAST_PERIOD); // [R7]
    end
    else
    begin
      if (srcTick)
      begin
        count_nxt = count_r + 8'h01;
      end
      // compared every clock, so equal writes match at once [R11] [R12] [R13]
      if (!matched_r && ({1'b0, count_r} == target))
      begin
        matched_nxt = 1'b1;
        pin_nxt = ~idleLevel; // [R15]
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      run_r <= 1'b0;
      mode_r <= CPW_MODE_RST;
      dutyLow_r <= CPW_DUTY_RST;
      dutyHigh_r <= CPW_DUTY_RST;
      dutyBuf_r <= CPW_EFF_RST;
      effDuty_r <= CPW_EFF_RST;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      count_r <= CPW_CNT_ZERO;
      period_r <= 4'h0;
      matched_r <= 1'b0;
      pin_r <= 1'b0;
      ovf_r <= 1'b0;
      sf_r <= 1'b0;
    end
    else
    begin
      run_r <= run_nxt;
      mode_r <= mode_nxt;
      dutyLow_r <= dutyLow_nxt;
      dutyHigh_r <= dutyHigh_nxt;
      dutyBuf_r <= dutyBuf_nxt;
      effDuty_r <= effDuty_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      count_r <= count_nxt;
      period_r <= period_nxt;
      matched_r <= matched_nxt;
      pin_r <= pin_nxt;
      ovf_r <= ovf_nxt;
      sf_r <= sf_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign modulatedOutPin = pin_r;
  assign overflowIrq = ovf_r;
  assign superframeIrq = sf_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_stop_clears: assert property (!run_r |=> count_r == CPW_CNT_ZERO && period_r == 4'h0) // [R1] [R19]
    else $error("stopped counter not cleared");
  chk_stop_idle: assert property (!run_r |=> pin_r == $past(idleLevel)) // [R2]
    else $error("stopped pin not at idle level");
  chk_wrap_ovf: assert property (wrap |=> ovf_r && count_r == CPW_CNT_ZERO && pin_r == $past(idleLevel)) // [R17]
    else $error("wrap did not idle the pin or pulse overflow");
  chk_sf_every16: assert property (sf_r |-> ovf_r && period_r == 4'h0) // [R7]
    else $error("superframe pulse off a sixteenth overflow");
  chk_commit_copy: assert property (commit && !hiWrite |=> effDuty_r == $past(dutyBuf_r)) // [R7]
    else $error("buffer not committed at superframe");
  chk_buf_hold: assert property (hiWrite && run_r && bufferEnableBit && !commit |=> $stable(effDuty_r)) // [R6]
    else $error("running buffered write reached effective duty");
  chk_direct_wr: assert property (hiWrite && (!bufferEnableBit || !run_r)
    |=> effDuty_r == dutyBuf_r && effDuty_r == {$past(pwdata[3:0]), $past(dutyLow_r)}) // [R9] [R10]
    else $error("direct write not effective");
  chk_match_edge: assert property (run_r && !wrap && !matched_r && {1'b0, count_r} == target
    |=> pin_r == ~idleLevel && matched_r) // [R15]
    else $error("match did not invert pin");
  chk_read_back: assert property ((psel && penable && !pwrite && paddr == CPW_OFS_DUTYHI && !pready_r)
    |=> prdata_r[3:0] == dutyBuf_r[11:8]) // [R8]
    else $error("duty read not last written");

  cov_superframe: cover property (sf_r);
  cov_stretch_match: cover property (stretch && matched_nxt && !matched_r);
  cov_buffered_commit: cover property (commit && dutyBuf_r != effDuty_r);
  cov_stop_run: cover property (run_r ##1 !run_r);

endmodule
`default_nettype wire

/* File: sim/cpw_load_model.sv */
// partner model: load on the pwm pin, external and low frequency clock sources
// assumes clk is the block clock; the bench reads the recorded run lengths
`timescale 1ns/1ps
`default_nettype none
module cpw_load_model (
  input wire logic clk,
  input wire logic idleLevel,
  input wire logic modulatedOutPin,
  output logic extClockPin,
  output logic lowFreqClock
);
  logic [2:0] phase = 3'h0;
  int runLen = 0;
  int runs[$];
  // ==========================================================
  // clock sources: each phase lasts 2 or 4 clk cycles
  assign extClockPin = phase[1];
  assign lowFreqClock = phase[2];
  always @(posedge clk)
  begin
    phase <= phase + 3'h1;
  end
  // length of each active level run on the pin
  always @(posedge clk)
  begin
    if (modulatedOutPin !== idleLevel)
      runLen <= runLen + 1;
    else if (runLen != 0)
    begin
      runs.push_back(runLen);
      runLen <= 0;
    end
  end
endmodule
`default_nettype wire

/* File: sim/cascaded_pwm12_buffer_test.sv */
// self-checking bench for the cascaded pwm block over apb
// assumes cpw_pkg register layout and the load model on the pin
`timescale 1ns/1ps
`default_nettype none
module cascaded_pwm12_buffer_test;
  import cpw_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, extClockPin, lowFreqClock, modulatedOutPin, overflowIrq, superframeIrq;
  logic idle = 1'b0;
  logic [7:0] d;
  logic [3:0] m;
  int failures = 0;
  int n_tests = 0;
  int nOvf = 0;
  int k;
  int divs[8] = '{2048, 1024, 256, 64, 16, 4, 2, 1};

  cpw_cascaded_pwm i_cpw_cascaded_pwm (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .extClockPin, .lowFreqClock, .modulatedOutPin, .overflowIrq, .superframeIrq);
  cpw_load_model i_cpw_load_model (.clk, .idleLevel(idle), .modulatedOutPin, .extClockPin, .lowFreqClock);

  // ==========================================================
  // clock, overflow pulse counter, watchdog
  initial forever #20 clk = ~clk;
  always @(posedge clk)
  begin
    if (overflowIrq === 1'b1)
      nOvf <= nOvf + 1;
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    failures++;
    end_of_test();
  end

  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && n++ < 20);
    if (pready !== 1'b1)
      failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  // low register first, high register loads the value
  task automatic writeDuty(input logic [7:0] dv, input logic [3:0] mv);
    wr(CPW_OFS_DUTYLO, {24'h0, dv[3:0], mv});
    wr(CPW_OFS_DUTYHI, {28'h0, dv[7:4]});
  endtask
  function automatic logic [31:0] mkMode(logic i, logic b, logic e, logic [2:0] s, logic l);
    return (32'(i) << CPW_MODE_IDLE) | (32'(b) << CPW_MODE_BUFEN) | (32'(e) << CPW_MODE_EXTCLK)
      | (32'(s) << CPW_MODE_SEL_LO) | (32'(l) << CPW_MODE_LOWSPD);
  endfunction
  function automatic int stretch(int n, logic [3:0] mv);
    return int'((mv[0] && n == 9) || (mv[1] && n % 8 == 5) || (mv[2] && n % 4 == 3) || (mv[3] && n % 2 == 0));
  endfunction
  // active run: from one clk after the match to the wrap
  function automatic int expLen(int dv, int s, int div);
    return (256 - dv - s) * div - 1;
  endfunction
  task automatic waitSf();
    int n;
    n = 0;
    while (superframeIrq !== 1'b1 && n++ < 5000) @(posedge clk);
    if (superframeIrq !== 1'b1)
      failures++;
    @(posedge clk);
  endtask
  // free count after two and a half source ticks from start
  task automatic rateChk(input logic [31:0] md, input int div);
    wr(CPW_OFS_CTRL, 32'h0);
    wr(CPW_OFS_MODE, md);
    wr(CPW_OFS_CTRL, 32'h1);
    repeat (div * 5 / 2) @(posedge clk);
    apb(1'b0, CPW_OFS_STATUS, 32'h0);
    check("tick count", 32'(rd[7:0] == 8'h02 || rd[7:0] == 8'h03), 32'h1);
  endtask
  // stop, set up, start, then compare n active runs
  task automatic pwmRun(input logic [31:0] md, input logic [7:0] dv, input logic [3:0] mv, input int div, input int n);
    int lim;
    lim = 0;
    wr(CPW_OFS_CTRL, 32'h0);
    wr(CPW_OFS_MODE, md);
    idle <= md[0];
    writeDuty(dv, mv);
    repeat (4) @(posedge clk);
    i_cpw_load_model.runs.delete();
    wr(CPW_OFS_CTRL, 32'h1);
    while (i_cpw_load_model.runs.size() < n && lim++ < 260 * div * n) @(posedge clk);
    if (i_cpw_load_model.runs.size() < n)
      failures++;
    for (int i = 0; i < n; i++)
      check("run length", i_cpw_load_model.runs[i], expLen(dv, stretch(i % 16 + 1, mv), div));
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(66178));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdchk("duty low reset", CPW_OFS_DUTYLO, 32'hff);
    rdchk("duty high reset", CPW_OFS_DUTYHI, 32'hff);
    rdchk("mode reset", CPW_OFS_MODE, 32'h0);
    rdchk("effective reset", CPW_OFS_EFFDUTY, 32'hfff);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    for (int t = 0; t < 3; t++)
    begin
      d = t == 0 ? 8'h00 : 8'($urandom_range(253));
      m = t == 0 ? 4'hf : 4'($urandom);
      pwmRun(mkMode(t[0], 1'b0, 1'b0, 3'h7, 1'b0), d, m, 1, 16);
    end
    for (int c = 3; c < 8; c++)
      pwmRun(mkMode(1'b0, 1'b0, 1'b0, 3'(c), 1'b0), 8'hfe, 4'h0, divs[c], 1);
    pwmRun(mkMode(1'b1, 1'b0, 1'b1, 3'h0, 1'b0), 8'hfe, 4'h0, 4, 1);
    for (int c = 0; c < 3; c++)
      rateChk(mkMode(1'b0, 1'b0, 1'b0, 3'(c), 1'b0), divs[c]);
    rateChk(mkMode(1'b0, 1'b0, 1'b0, 3'h0, 1'b0) | (32'h1 << CPW_MODE_SLOWPRE), 128);
    rateChk(mkMode(1'b0, 1'b0, 1'b0, 3'h1, 1'b0) | (32'h1 << CPW_MODE_SLOWPRE), 64);
    pwmRun(mkMode(1'b0, 1'b0, 1'b0, 3'h7, 1'b1), 8'hfe, 4'h0, 32, 1);
    // low speed with a gear only code gives no ticks
    wr(CPW_OFS_CTRL, 32'h0);
    wr(CPW_OFS_MODE, mkMode(1'b0, 1'b0, 1'b0, 3'h3, 1'b1));
    wr(CPW_OFS_CTRL, 32'h1);
    repeat (300) @(posedge clk);
    apb(1'b0, CPW_OFS_STATUS, 32'h0);
    check("invalid code status", rd & 32'h3fff, 32'h2000);
    // mode locked while running, unbuffered write at once, stop
    pwmRun(mkMode(1'b1, 1'b0, 1'b0, 3'h7, 1'b0), 8'h80, 4'h0, 1, 1);
    wr(CPW_OFS_MODE, 32'h0);
    rdchk("mode locked", CPW_OFS_MODE, mkMode(1'b1, 1'b0, 1'b0, 3'h7, 1'b0));
    writeDuty(8'h41, 4'h3);
    rdchk("effective now", CPW_OFS_EFFDUTY, 32'h413);
    wr(CPW_OFS_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    apb(1'b0, CPW_OFS_STATUS, 32'h0);
    check("stopped status", rd & 32'h3fff, 32'h1000);
    // buffered: stopped write hits both, running write waits
    pwmRun(mkMode(1'b0, 1'b1, 1'b0, 3'h7, 1'b0), 8'h20, 4'h1, 1, 1);
    rdchk("effective stopped", CPW_OFS_EFFDUTY, 32'h201);
    writeDuty(8'hc5, 4'h6);
    rdchk("effective held", CPW_OFS_EFFDUTY, 32'h201);
    rdchk("duty low read", CPW_OFS_DUTYLO, 32'h56);
    rdchk("duty high read", CPW_OFS_DUTYHI, 32'h0c);
    waitSf();
    k = nOvf;
    rdchk("effective commit", CPW_OFS_EFFDUTY, 32'hc56);
    waitSf();
    check("overflows per superframe", 32'(nOvf - k), 32'd16);
    end_of_test();
  end
endmodule
`default_nettype wire
